// [include/strap_pkg.sv]
/*
  Shared constants and carrier types for the strap configuration loader:
  register offsets, field positions, reset values, pin vector layout and
  the divider that makes the reference-clock enable.
  Assumes a single 100 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
package strap_pkg;

  localparam int CLK_MHZ = 100;
  localparam int REF_MHZ = 50;
  localparam int REF_DIV = CLK_MHZ / REF_MHZ;

  localparam int AXI_AW = 12;
  localparam int ADDR_W = 5;

  localparam logic [AXI_AW-1:0] OFF_CTRL    = 12'h000;
  localparam logic [AXI_AW-1:0] OFF_MODE    = 12'h004;
  localparam logic [AXI_AW-1:0] OFF_PHYADDR = 12'h008;
  localparam logic [AXI_AW-1:0] OFF_STATUS  = 12'h00c;

  localparam int CTRL_SOFT_RST_BIT = 0;
  localparam int CTRL_PWRDN_BIT    = 1;

  localparam int STAT_ADDR_BIT   = 0;
  localparam int STAT_REGULATOR_DISABLE_STRAP_BIT = 1;
  localparam int STAT_IRQSEL_BIT = 2;
  localparam int STAT_MODE_LSB   = 4;
  localparam int STAT_CLKOUT_BIT = 7;
  localparam int STAT_RUN_BIT    = 8;
  localparam int STAT_RXOVF_BIT  = 9;

  localparam logic [ADDR_W-1:0] PHYADDR_RST = 5'h00;
  localparam logic [2:0]        MODE_RST    = 3'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int RXBUF_DEPTH = 8;
  localparam int RXBUF_AW    = 3;

  localparam int PIN_W        = 7;
  localparam int PIN_MODE_LSB = 0;
  localparam int PIN_RXER     = 3;
  localparam int PIN_LINK_ACTIVITY_LED     = 4;
  localparam int PIN_LINK_SPEED_LED     = 5;
  localparam int PIN_RST      = 6;

  typedef struct packed {
    logic [2:0] mode;
    logic       irq_sel;
    logic       regulator_disable_strap;
    logic       addr_lsb;
  } strap_t;

  // unconnected straps: select pulls up, the rest pull down
  localparam strap_t STRAP_RST = '{mode: 3'h0, irq_sel: 1'b1, regulator_disable_strap: 1'b0, addr_lsb: 1'b0};

  typedef struct packed {
    logic       en;
    logic [1:0] d;
  } rmii_t;

endpackage : strap_pkg

// [rtl/strap_loader.sv]
/*
  Reset-time strap capture for a 10/100 PHY, with the run-time use of the
  shared strap pins, the interrupt / reference-clock output select, the
  management address match, the RMII transmit path and receive elasticity
  buffer, and an AXI4-Lite register slave.
  Assumes: 100 MHz clock, arst_n asynchronous active low, strap pins and
  pin_reset_n come from outside the clock domain.
*/
// Functional notes
// - sample and hold all straps at power-on reset and at pin reset
// - address strap captured when hardware reset ends, default zero
// - answer only management frames whose address equals ours
// - our configured address seeds the transmit scrambler
// - strapping gives address 0 or 1 only; higher needs a software write
// - software may write a new address, we then answer there
// - address strap pin is input in reset, receive-error output afterwards
// - pin reset release loads mode bits from three mode straps
// - soft reset keeps mode bits, no strap reload
// - regulator-disable strap high turns the internal core regulator off
// - regulator-disable strap low or floating keeps the regulator on
// - select strap latched at power-on and pin reset rising edge
// - floating select strap means interrupt mode with external clock
// - clock-output mode drives 50 MHz reference, interrupt unavailable
// - generated reference clock comes from the oscillator source
// - generated reference stops in either power-down mode
// - transmit path timed from reference clock, no buffering
// - received data passes an elasticity buffer into reference timing
// - regulator strap high makes activity LED active low
// - select strap high makes speed LED active low
module strap_loader
  import strap_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  input  wire logic [AXI_AW-1:0]     awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [AXI_AW-1:0]     araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic                  pin_reset_n,
  input  wire logic [2:0]            mode_strap,
  input  wire logic                  rxer_pin_in,
  output logic                       rxer_pin_out,
  output logic                       rxer_pin_oe,
  input  wire logic                  link_activity_led_pin_in,
  output logic                       link_activity_led_pin_out,
  output logic                       link_activity_led_pin_oe,
  input  wire logic                  link_speed_led_pin_in,
  output logic                       link_speed_led_pin_out,
  output logic                       link_speed_led_pin_oe,
  output logic                       irq_refclk_pin_out,
  output logic                       irq_refclk_pin_oe,
  input  wire logic                  irq_request_n,
  input  wire logic                  link_activity,
  input  wire logic                  link_speed,
  input  wire logic                  rx_error,
  input  wire logic                  energy_detect_powerdown,
  output logic                       regulator_enable,
  input  wire logic [ADDR_W-1:0]     mgmt_frame_addr,
  output logic                       mgmt_addr_match,
  output logic [ADDR_W-1:0]          phy_address_field,
  output logic [ADDR_W-1:0]          scrambler_seed,
  output logic [2:0]                 block_mode,
  output logic                       soft_reset_pulse,
  output logic                       general_powerdown,
  output strap_pkg::strap_t          latched_straps,
  output logic                       ref_clk_en,
  input  wire strap_pkg::rmii_t      tx_in,
  output strap_pkg::rmii_t           tx_out,
  input  wire strap_pkg::rmii_t      rx_rec,
  output strap_pkg::rmii_t           rx_out
);

  function automatic logic addr_is(input logic [AXI_AW-1:0] a, input logic [AXI_AW-1:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  function automatic logic addr_mapped(input logic [AXI_AW-1:0] a);
    addr_mapped = addr_is(a, OFF_CTRL) | addr_is(a, OFF_MODE) |
                  addr_is(a, OFF_PHYADDR) | addr_is(a, OFF_STATUS);
  endfunction : addr_mapped

  // reset release through two flops
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) rst_sync_q <= 2'h0;
    else         rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // pin inputs: three flops, a change counts when stages two and three agree
  logic [PIN_W-1:0] pin_vec;
  logic [PIN_W-1:0] s1_q;
  logic [PIN_W-1:0] s2_q;
  logic [PIN_W-1:0] s3_q;
  logic [PIN_W-1:0] filt_q;
  logic [PIN_W-1:0] filt_d;

  assign pin_vec = {pin_reset_n, link_speed_led_pin_in, link_activity_led_pin_in, rxer_pin_in, mode_strap};
  assign filt_d  = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q   <= 7'h00;
      s2_q   <= 7'h00;
      s3_q   <= 7'h00;
      filt_q <= 7'h00;
    end else begin
      s1_q   <= pin_vec;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  // capture at the release of pin reset; after power-on the filtered reset
  // starts low, so the first release also covers the power-on capture
  logic   cap;
  logic   cfg_valid_q;
  logic   run;
  strap_t strap_now;
  strap_t strap_q;

  assign cap = filt_d[PIN_RST] & ~filt_q[PIN_RST];
  assign run = filt_q[PIN_RST] & cfg_valid_q;
  assign strap_now = '{mode:     filt_d[PIN_MODE_LSB +: 3],
                       irq_sel:  filt_d[PIN_LINK_SPEED_LED],
                       regulator_disable_strap:   filt_d[PIN_LINK_ACTIVITY_LED],
                       addr_lsb: filt_d[PIN_RXER]};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_q     <= STRAP_RST;
      cfg_valid_q <= 1'b0;
    end else if (cap) begin
      strap_q     <= strap_now;
      cfg_valid_q <= 1'b1;
    end
  end

  assign latched_straps   = strap_q;
  assign regulator_enable = ~strap_q.regulator_disable_strap;

  // register bus: address and data taken in either order
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              do_write;
  logic              do_read;
  logic              wr_ctrl;
  logic              wr_mode;
  logic              wr_addr;
  logic [31:0]       rd_word;

  assign awready  = ~aw_hold_q;
  assign wready   = ~w_hold_q;
  assign arready  = ~rvalid_q;
  assign bvalid   = bvalid_q;
  assign bresp    = bresp_q;
  assign rvalid   = rvalid_q;
  assign rdata    = rdata_q;
  assign rresp    = rresp_q;
  assign do_write = aw_hold_q & w_hold_q & ~bvalid_q;
  assign do_read  = arvalid & ~rvalid_q;
  assign wr_ctrl  = do_write & wstrb_q[0] & addr_is(awaddr_q, OFF_CTRL);
  assign wr_mode  = do_write & wstrb_q[0] & addr_is(awaddr_q, OFF_MODE);
  assign wr_addr  = do_write & wstrb_q[0] & addr_is(awaddr_q, OFF_PHYADDR);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (awvalid && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= awaddr;
      end else if (do_write) begin
        aw_hold_q <= 1'b0;
      end
      if (wvalid && !w_hold_q) begin
        w_hold_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end else if (do_write) begin
        w_hold_q <= 1'b0;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q  <= addr_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (do_read) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // configuration registers
  logic [ADDR_W-1:0] phy_addr_q;
  logic [2:0]        mode_q;
  logic              pwrdn_q;
  logic              soft_rst_q;
  logic              rx_ovf_q;
  logic              clkout_mode;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phy_addr_q <= PHYADDR_RST;
      mode_q     <= MODE_RST;
      pwrdn_q    <= 1'b0;
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_ctrl & wdata_q[CTRL_SOFT_RST_BIT];
      if (wr_ctrl) pwrdn_q <= wdata_q[CTRL_PWRDN_BIT];
      if (cap) begin
        phy_addr_q <= {4'h0, strap_now.addr_lsb};
        mode_q     <= strap_now.mode;
      end else begin
        if (wr_addr) phy_addr_q <= wdata_q[ADDR_W-1:0];
        if (wr_mode) mode_q <= wdata_q[2:0];
      end
    end
  end

  assign rd_word = addr_is(araddr, OFF_CTRL)    ? {30'h0, pwrdn_q, 1'b0} :
                   addr_is(araddr, OFF_MODE)    ? {29'h0, mode_q} :
                   addr_is(araddr, OFF_PHYADDR) ? {27'h0, phy_addr_q} :
                   addr_is(araddr, OFF_STATUS)  ? {22'h0, rx_ovf_q, run, clkout_mode,
                                                   strap_q.mode, 1'b0, strap_q.irq_sel,
                                                   strap_q.regulator_disable_strap, strap_q.addr_lsb} :
                   32'h0000_0000;

  assign phy_address_field = phy_addr_q;
  assign scrambler_seed    = phy_addr_q;
  assign block_mode        = mode_q;
  assign soft_reset_pulse  = soft_rst_q;
  assign general_powerdown = pwrdn_q;

  // management address compare
  logic match_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) match_q <= 1'b0;
    else        match_q <= run & (mgmt_frame_addr == phy_addr_q);
  end
  assign mgmt_addr_match = match_q;

  // reference timing: a 50 MHz enable and the generated clock output,
  // both divided from the core clock standing in for the oscillator
  logic ref_phase_q;
  logic refout_q;
  logic ref_stop;
  logic irq_q;

  assign clkout_mode = run & ~strap_q.irq_sel;
  assign ref_stop    = pwrdn_q | energy_detect_powerdown;
  assign ref_clk_en  = ref_phase_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_phase_q <= 1'b0;
      refout_q    <= 1'b0;
      irq_q       <= 1'b1;
    end else begin
      ref_phase_q <= ~ref_phase_q;
      refout_q    <= clkout_mode & ~ref_stop & ~refout_q;
      irq_q       <= irq_request_n;
    end
  end

  assign irq_refclk_pin_out = clkout_mode ? refout_q : irq_q;
  assign irq_refclk_pin_oe  = run;

  // shared strap pins take their run-time roles only after capture
  logic link_activity_led_q;
  logic link_speed_led_q;
  logic rxer_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_activity_led_q <= 1'b0;
      link_speed_led_q <= 1'b0;
      rxer_q <= 1'b0;
    end else begin
      link_activity_led_q <= link_activity ^ strap_q.regulator_disable_strap;
      link_speed_led_q <= link_speed ^ strap_q.irq_sel;
      rxer_q <= rx_error;
    end
  end

  assign link_activity_led_pin_out = link_activity_led_q;
  assign link_speed_led_pin_out = link_speed_led_q;
  assign rxer_pin_out = rxer_q;
  assign link_activity_led_pin_oe  = run;
  assign link_speed_led_pin_oe  = run;
  assign rxer_pin_oe  = run;

  // transmit: straight register on the reference enable
  rmii_t tx_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)          tx_q <= '0;
    else if (ref_clk_en) tx_q <= tx_in;
  end
  assign tx_out = tx_q;

  // receive: elasticity buffer from recovered strobes to reference enable
  rmii_t             rxbuf [RXBUF_DEPTH];
  logic [RXBUF_AW:0] wr_ptr_q;
  logic [RXBUF_AW:0] rd_ptr_q;
  logic              rx_empty;
  logic              rx_full;
  logic              rx_push;
  logic              rx_pop;
  rmii_t             rx_q;

  assign rx_empty = (wr_ptr_q == rd_ptr_q);
  assign rx_full  = (wr_ptr_q[RXBUF_AW-1:0] == rd_ptr_q[RXBUF_AW-1:0]) &
                    (wr_ptr_q[RXBUF_AW] != rd_ptr_q[RXBUF_AW]);
  assign rx_push  = rx_rec.en & ~rx_full;
  assign rx_pop   = ref_clk_en & ~rx_empty;

  always_ff @(posedge clock) begin
    if (rx_push) rxbuf[wr_ptr_q[RXBUF_AW-1:0]] <= rx_rec;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      rx_q     <= '0;
      rx_ovf_q <= 1'b0;
    end else begin
      if (rx_push) wr_ptr_q <= wr_ptr_q + 4'h1;
      if (rx_pop) begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
        rx_q     <= rxbuf[rd_ptr_q[RXBUF_AW-1:0]];
      end else if (ref_clk_en) begin
        rx_q <= '0;
      end
      if (rx_rec.en && rx_full) rx_ovf_q <= 1'b1;
      else if (cap)             rx_ovf_q <= 1'b0;
    end
  end
  assign rx_out = rx_q;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_gen_run;
    clkout_mode && !ref_stop;
  endsequence

  property p_cap_hold;
    cap |=> strap_q == $past(strap_now);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("strap capture lost");

  property p_addr_strap;
    cap |=> phy_addr_q == {4'h0, $past(strap_now.addr_lsb)};
  endproperty
  a_addr_strap: assert property (p_addr_strap) else $error("strap address wrong");

  property p_match;
    mgmt_addr_match |-> $past(mgmt_frame_addr) == $past(phy_addr_q);
  endproperty
  a_match: assert property (p_match) else $error("match on foreign address");

  property p_sw_addr;
    wr_addr && !cap |=> phy_addr_q == $past(wdata_q[ADDR_W-1:0]);
  endproperty
  a_sw_addr: assert property (p_sw_addr) else $error("address write lost");

  property p_mode_load;
    cap |=> mode_q == $past(strap_now.mode);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode not loaded");

  property p_soft_keep;
    soft_rst_q && !$past(cap) |-> $stable(mode_q) && $stable(phy_addr_q);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset changed config");

  property p_straps_stable;
    !cap |=> $stable(strap_q);
  endproperty
  a_straps_stable: assert property (p_straps_stable) else $error("straps moved");

  property p_clk_toggles;
    s_gen_run ##1 s_gen_run |-> refout_q != $past(refout_q);
  endproperty
  a_clk_toggles: assert property (p_clk_toggles) else $error("ref clock stalled");

  property p_clk_stops;
    ref_stop |=> !refout_q;
  endproperty
  a_clk_stops: assert property (p_clk_stops) else $error("ref clock in power-down");

  property p_rxer_oe;
    !run |-> !rxer_pin_oe && !link_activity_led_pin_oe && !link_speed_led_pin_oe;
  endproperty
  a_rxer_oe: assert property (p_rxer_oe) else $error("strap pin driven in reset");

  property p_link_activity_led_pol;
    strap_q.regulator_disable_strap ##1 strap_q.regulator_disable_strap |-> link_activity_led_pin_out == !$past(link_activity);
  endproperty
  a_link_activity_led_pol: assert property (p_link_activity_led_pol) else $error("activity led polarity");

  property p_link_speed_led_pol;
    !strap_q.irq_sel ##1 !strap_q.irq_sel |-> link_speed_led_pin_out == $past(link_speed);
  endproperty
  a_link_speed_led_pol: assert property (p_link_speed_led_pol) else $error("speed led polarity");

  property p_irq_mode;
    (run && strap_q.irq_sel) [*2] |-> irq_refclk_pin_out == $past(irq_request_n);
  endproperty
  a_irq_mode: assert property (p_irq_mode) else $error("interrupt not on pin");

  property p_tx_direct;
    ref_clk_en |=> tx_out == $past(tx_in);
  endproperty
  a_tx_direct: assert property (p_tx_direct) else $error("tx not passed");

  property p_reg_off;
    strap_q.regulator_disable_strap && !cap |-> !regulator_enable ##1 strap_q.regulator_disable_strap;
  endproperty
  a_reg_off: assert property (p_reg_off) else $error("regulator state wrong");

endmodule : strap_loader

// [verification/strap_board.sv]
/*
  Board side of the strap loader: strap resistors on the shared pins and
  a MAC that counts edges of the generated reference clock.
  Assumes the loader splits each shared pin into in, out and enable.
*/
module strap_board
  import strap_pkg::*;
(
  input  wire logic              clock,
  input  wire strap_pkg::strap_t cfg,
  input  wire logic              rxer_pin_out,
  input  wire logic              rxer_pin_oe,
  input  wire logic              link_activity_led_pin_out,
  input  wire logic              link_activity_led_pin_oe,
  input  wire logic              link_speed_led_pin_out,
  input  wire logic              link_speed_led_pin_oe,
  input  wire logic              irq_refclk_pin_out,
  input  wire logic              irq_refclk_pin_oe,
  output logic                   rxer_pin_in,
  output logic                   link_activity_led_pin_in,
  output logic                   link_speed_led_pin_in,
  output logic [2:0]             mode_strap,
  output int                     refclk_edges
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q = 1'h0;
  initial refclk_edges = 0;
  // resistor level wins only while the loader leaves the pin alone
  assign rxer_pin_in = rxer_pin_oe ? rxer_pin_out : cfg.addr_lsb;
  assign link_activity_led_pin_in = link_activity_led_pin_oe ? link_activity_led_pin_out : cfg.regulator_disable_strap;
  assign link_speed_led_pin_in = link_speed_led_pin_oe ? link_speed_led_pin_out : cfg.irq_sel;
  // mode pins carry other traffic once running
  assign mode_strap  = rxer_pin_oe ? ~cfg.mode : cfg.mode;
  always @(posedge clock) begin
    last_q <= irq_refclk_pin_out;
    if (irq_refclk_pin_oe && irq_refclk_pin_out != last_q) begin
      refclk_edges <= refclk_edges + 1;
    end
  end
endmodule : strap_board

// [verification/tb_top.sv]
/*
  Self-checking bench for strap_loader: strap capture, shared pin use,
  address match, soft reset, reference clock and register access.
  Assumes strap_board stands on the pin side.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import strap_pkg::*;
  logic              clock = 1'h0, arst_n = 1'h0, pin_reset_n = 1'h0;
  logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic              arvalid = 1'h0, rready = 1'h0;
  logic [31:0]       wdata = '0, rdata, d;
  logic [3:0]        wstrb = 4'hf;
  logic [1:0]        bresp, rresp, r;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [2:0]        mode_strap, block_mode;
  logic              rxer_pin_in, rxer_pin_out, rxer_pin_oe, link_activity_led_pin_in;
  logic              link_activity_led_pin_out, link_activity_led_pin_oe, link_speed_led_pin_in, link_speed_led_pin_out;
  logic              link_speed_led_pin_oe, irq_refclk_pin_out, irq_refclk_pin_oe;
  logic              irq_request_n = 1'h1, link_activity = 1'h0, link_speed = 1'h0;
  logic              rx_error = 1'h0, energy_detect_powerdown = 1'h0;
  logic              regulator_enable, mgmt_addr_match, soft_reset_pulse;
  logic              general_powerdown, ref_clk_en;
  logic [ADDR_W-1:0] mgmt_frame_addr = '0, phy_address_field, scrambler_seed, a;
  strap_t            cfg = STRAP_RST, latched_straps, exp;
  rmii_t             tx_in = '0, tx_out, rx_rec = '0, rx_out;
  int                n_errors = 0, compares = 0, refclk_edges, k, n, e0, n_pulse = 0;

  strap_loader uut (.clock, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .pin_reset_n, .mode_strap, .rxer_pin_in, .rxer_pin_out,
    .rxer_pin_oe, .link_activity_led_pin_in, .link_activity_led_pin_out, .link_activity_led_pin_oe, .link_speed_led_pin_in,
    .link_speed_led_pin_out, .link_speed_led_pin_oe, .irq_refclk_pin_out, .irq_refclk_pin_oe,
    .irq_request_n, .link_activity, .link_speed, .rx_error, .energy_detect_powerdown,
    .regulator_enable, .mgmt_frame_addr, .mgmt_addr_match, .phy_address_field,
    .scrambler_seed, .block_mode, .soft_reset_pulse, .general_powerdown,
    .latched_straps, .ref_clk_en, .tx_in, .tx_out, .rx_rec, .rx_out);
  strap_board board (.clock, .cfg, .rxer_pin_out, .rxer_pin_oe, .link_activity_led_pin_out,
    .link_activity_led_pin_oe, .link_speed_led_pin_out, .link_speed_led_pin_oe, .irq_refclk_pin_out,
    .irq_refclk_pin_oe, .rxer_pin_in, .link_activity_led_pin_in, .link_speed_led_pin_in, .mode_strap,
    .refclk_edges);

  // the core clock stands in for the single oscillator feeding both ends
  always #5 clock = ~clock;
  always @(posedge clock) if (soft_reset_pulse === 1'h1) n_pulse++;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [AXI_AW-1:0] ad, input logic [31:0] v);
    awaddr <= ad;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'h0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [AXI_AW-1:0] ad);
    araddr <= ad;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge clock);
  endtask : rd

  task automatic capture(input strap_t s);
    pin_reset_n <= 1'h0;
    cfg <= s;
    repeat (8) @(posedge clock);
    pin_reset_n <= 1'h1;
    n = 0;
    while (!rxer_pin_oe && n < 40) begin
      @(posedge clock);
      n++;
    end
    chk(n < 40, 1);
    @(posedge clock);
  endtask : capture

  task automatic stop_test();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    #100us;
    n_errors++;
    stop_test();
  end

  initial begin
    void'($urandom(32'hbd6dbfc4));
    repeat (6) @(posedge clock);
    arst_n <= 1'h1;
    repeat (2) @(posedge clock);
    for (k = 0; k < 4; k++) begin
      exp = '{mode: 3'($urandom), irq_sel: k[0], regulator_disable_strap: k[1], addr_lsb: 1'($urandom)};
      capture(exp);
      chk(latched_straps, exp);
      chk(phy_address_field, {4'h0, exp.addr_lsb});
      chk(scrambler_seed, {4'h0, exp.addr_lsb});
      chk(block_mode, exp.mode);
      chk(regulator_enable, !exp.regulator_disable_strap);
      rd(OFF_STATUS);
      chk({d[9:4], d[2:0], r}, {2'h1, !exp.irq_sel, exp.mode, exp.irq_sel, exp.regulator_disable_strap,
           exp.addr_lsb, RESP_OKAY});
      link_activity <= 1'($urandom);
      link_speed <= 1'($urandom);
      rx_error <= 1'($urandom);
      irq_request_n <= 1'($urandom);
      cfg <= strap_t'(6'($urandom));
      repeat (3) @(posedge clock);
      chk(link_activity_led_pin_out, link_activity ^ exp.regulator_disable_strap);
      chk(link_speed_led_pin_out, link_speed ^ exp.irq_sel);
      chk({link_activity_led_pin_oe, link_speed_led_pin_oe, irq_refclk_pin_oe, rxer_pin_oe, rxer_pin_out},
          {4'hf, rx_error});
      chk(latched_straps, exp);
      e0 = refclk_edges;
      repeat (20) @(posedge clock);
      chk(refclk_edges - e0, exp.irq_sel ? 0 : 20);
      if (exp.irq_sel) chk(irq_refclk_pin_out, irq_request_n);
      else begin
        energy_detect_powerdown <= 1'h1;
        repeat (4) @(posedge clock);
        e0 = refclk_edges;
        repeat (10) @(posedge clock);
        chk(refclk_edges - e0, 0);
        energy_detect_powerdown <= 1'h0;
        wr(OFF_CTRL, 32'h2);
        chk(general_powerdown, 1);
        repeat (4) @(posedge clock);
        e0 = refclk_edges;
        repeat (10) @(posedge clock);
        chk(refclk_edges - e0, 0);
        wr(OFF_CTRL, 32'h0);
      end
      $display("capture test %0d done", k);
    end
    wr(OFF_PHYADDR, 32'h13);
    chk(r, RESP_OKAY);
    chk({phy_address_field, scrambler_seed}, {5'h13, 5'h13});
    for (k = 0; k < 3; k++) begin
      a = (k == 0) ? 5'h13 : (k == 1) ? 5'h01 : 5'($urandom);
      mgmt_frame_addr <= a;
      repeat (2) @(posedge clock);
      chk(mgmt_addr_match, a == 5'h13);
    end
    $display("address test done");
    wr(OFF_MODE, 32'h5);
    wr(OFF_CTRL, 32'h1);
    rd(OFF_MODE);
    chk({n_pulse[3:0], block_mode, d[2:0], r}, {4'h1, 3'h5, 3'h5, RESP_OKAY});
    chk(latched_straps, exp);
    rd(12'h010);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    $display("register test done");
    tx_in <= rmii_t'(3'($urandom));
    repeat (4) @(posedge clock);
    chk(tx_out, tx_in);
    rx_rec <= rmii_t'(3'h6);
    @(posedge clock);
    rx_rec <= '0;
    n = 0;
    while (rx_out !== rmii_t'(3'h6) && n < 8) begin
      @(posedge clock);
      n++;
    end
    chk(n < 8, 1);
    n = ref_clk_en;
    @(posedge clock);
    chk(ref_clk_en, !n);
    // push every cycle, pop every other: the buffer must overflow
    rx_rec <= rmii_t'(3'h4);
    repeat (24) @(posedge clock);
    rx_rec <= '0;
    rd(OFF_STATUS);
    chk(d[9], 1);
    $display("rmii test done");
    stop_test();
  end
endmodule : tb_top
